// File: hw/kbcm_host_mailbox.sv
// keyboard controller host mailbox: host port, flags, irqs, pins, power
`timescale 1ns/1ps

// -------------------------------------------------------------------
// output byte queue
// -------------------------------------------------------------------
module kbcm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } kbcm_fifo_st_t;
  kbcm_fifo_st_t s;
  kbcm_fifo_st_t next_s;
  logic          push;
  logic          pop;

  assign in_ready  = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// -------------------------------------------------------------------
// mailbox top
// -------------------------------------------------------------------
module kbcm_host_mailbox
  import kbcm_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  kbcm_host_req_t           host_req,
  output kbcm_host_rsp_t           host_rsp,
  output logic                     kbd_host_irq,
  output logic                     aux_host_irq,
  input  wire logic                cpu_data_wr,
  input  wire logic [7:0]          cpu_data_port,
  output logic                     cpu_data_ready,
  input  wire logic                cpu_obf_clr,
  input  wire logic                cpu_in_rd,
  output logic [7:0]               cpu_input_port,
  output logic [7:0]               cpu_status,
  input  wire logic                cpu_status_wr,
  input  wire logic [7:0]          cpu_status_wdata,
  input  wire logic                cpu_en_flags,
  input  wire logic                cpu_port2_wr,
  input  wire logic [7:0]          cpu_port2_wdata,
  output logic [7:0]               cpu_port2,
  output logic                     port2_bit1,
  output logic                     test_input_zero,
  output logic                     test_input_one,
  output logic                     port1_bit0,
  output logic                     port1_bit1,
  input  wire logic                ibf_irq_en,
  input  wire logic                tmr_irq_en,
  input  wire logic                cpu_timer_ovf,
  input  wire logic                cpu_timer_ack,
  output logic                     cpu_irq_ibf,
  output logic                     cpu_irq_timer,
  input  wire logic                cpu_halt,
  input  wire logic                cpu_stop,
  output logic                     alu_clk_en,
  output logic                     osc_en,
  output logic                     cpu_core_rst,
  output logic                     cpu_wake_call,
  input  wire logic                kbc_mode,
  input  wire logic                pin_open_drain,
  input  wire logic [NUM_PINS-1:0] gp_invert,
  input  wire logic [NUM_PINS-1:0] gp_as_input,
  input  wire logic [NUM_PINS-1:0] kbm_pin_in,
  output logic [NUM_PINS-1:0]      kbm_pin_out,
  output logic [NUM_PINS-1:0]      kbm_pin_oe
);

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  function automatic int pin_port_bit(input int idx);
    unique case (idx)
      0:       pin_port_bit = P2_KBD_CLOCK_PIN;
      1:       pin_port_bit = P2_KBD_DATA_PIN;
      2:       pin_port_bit = P2_MCLK;
      default: pin_port_bit = P2_MOUSE_DATA_PIN;
    endcase
  endfunction

  kbcm_state_t s;
  kbcm_state_t next_s;
  logic        data_hit;
  logic        cmd_hit;
  logic        host_data_wr;
  logic        host_cmd_wr;
  logic        host_data_rd;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [7:0]  fifo_data;

  // rule 01/02: only the two documented addresses answer; other selected reads still return UNMAPPED_RDATA with valid set
  // data and command port decode
  assign data_hit     = host_req.cs & (host_req.addr == ADDR_DATA);
  assign cmd_hit      = host_req.cs & (host_req.addr == ADDR_CMD);
  assign host_data_wr = host_req.wr & data_hit;
  assign host_cmd_wr  = host_req.wr & cmd_hit;
  assign host_data_rd = host_req.rd & data_hit;
  assign fifo_pop     = fifo_valid & ~s.status[ST_OBF];

  // -----------------------------------------------------------------
  // output byte path
  // -----------------------------------------------------------------
  // bytes queue here so firmware can run ahead of a slow host
  kbcm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (cpu_data_wr),
    .in_ready  (cpu_data_ready),
    .in_data   (cpu_data_port),
    .out_valid (fifo_valid),
    .out_ready (~s.status[ST_OBF]),
    .out_data  (fifo_data)
  );

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_s               = s;
    next_s.rsp.valid     = 1'b0;
    next_s.wake_call     = 1'b0;
    next_s.pin_fb        = kbm_pin_in;
    // clears are applied first so that sets below win
    if (cpu_status_wr) begin
      next_s.status = (s.status & ~ST_UD_MASK) | (cpu_status_wdata & ST_UD_MASK);
    end
    if (cpu_in_rd) begin
      next_s.status[ST_IBF] = 1'b0;
    end
    if (cpu_obf_clr) begin
      next_s.status[ST_OBF] = 1'b0;
    end
    if (cpu_en_flags) begin
      next_s.en_flags = 1'b1;
    end
    if (host_req.rd && (data_hit || cmd_hit)) begin
      next_s.rsp.valid = 1'b1;
      next_s.rsp.data  = data_hit ? s.out_data : s.status;
    end else if (host_req.rd && host_req.cs) begin
      next_s.rsp.valid = 1'b1;
      next_s.rsp.data  = UNMAPPED_RDATA;
    end
    if (host_data_rd && s.en_flags) begin
      next_s.status[ST_OBF] = 1'b0;
    end
    if (fifo_pop) begin
      next_s.out_data       = fifo_data;
      next_s.status[ST_OBF] = 1'b1;
    end
    if (host_data_wr || host_cmd_wr) begin
      next_s.in_data        = host_req.wdata;
      next_s.status[ST_IBF] = 1'b1;
      next_s.status[ST_CD]  = host_req.addr[ADDR_SEL_BIT];
    end
    if (cpu_timer_ack) begin
      next_s.tmr_flag = 1'b0;
    end
    if (cpu_timer_ovf) begin
      next_s.tmr_flag = 1'b1;
    end
    if (cpu_port2_wr) begin
      next_s.port2 = cpu_port2_wdata;
    end
    next_s.kbd_irq = next_s.en_flags
                   ? (next_s.port2[P2_KBD_HOST_IRQ] & next_s.status[ST_OBF])
                   : next_s.port2[P2_KBD_HOST_IRQ];
    // aux irq from its port bit, gated by inverted input full when flags are enabled
    next_s.aux_irq = next_s.en_flags
                   ? (next_s.port2[P2_AIRQ] & ~next_s.status[ST_IBF])
                   : next_s.port2[P2_AIRQ];
    // a falling port bit (rising pin) opens the drive-high window
    for (int i = 0; i < NUM_PINS; i++) begin
      if (next_s.port2[pin_port_bit(i)] == 1'b0 && s.port2[pin_port_bit(i)] == 1'b1) begin
        next_s.drv_cnt[i] = DRV_W'(DRIVE_HIGH_CYC);
      end else if (s.drv_cnt[i] != '0) begin
        next_s.drv_cnt[i] = s.drv_cnt[i] - 1'b1;
      end
    end
    // core held in reset even if the pin pulse was short
    if (s.rst_cnt != '0 && s.pwr != PWR_HARD) begin
      next_s.rst_cnt = s.rst_cnt - 1'b1;
    end
    unique case (s.pwr)
      PWR_RUN: begin
        if (cpu_stop) begin
          next_s.pwr = PWR_HARD;
        end else if (cpu_halt) begin
          next_s.pwr = PWR_SOFT;
        end
      end
      PWR_SOFT: begin
        // host data byte resumes, via handler if enabled
        if (host_data_wr) begin
          next_s.pwr       = PWR_RUN;
          next_s.wake_call = ibf_irq_en;
        end
      end
      PWR_HARD: begin
        // oscillator needs settle time before code runs
        if (host_data_wr) begin
          next_s.pwr     = PWR_RUN;
          next_s.rst_cnt = RST_W'(RESET_HOLD_CYC);
        end
      end
    endcase
  end

  // pins low and status zero after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // -----------------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------------
  // active-high drive is only a speed-up; the pull-up holds the level
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    logic lvl;
    // pins carry the inverted port bit
    // general purpose settings ignored in controller mode
    assign lvl = ~s.port2[pin_port_bit(g)] ^ (~kbc_mode & gp_invert[g]);
    assign kbm_pin_out[g] = lvl;
    assign kbm_pin_oe[g] = (~kbc_mode & gp_as_input[g]) ? 1'b0 :
                           ~lvl | (~pin_open_drain & (s.drv_cnt[g] != '0));
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign host_rsp        = s.rsp;
  assign kbd_host_irq    = s.kbd_irq;
  assign aux_host_irq    = s.aux_irq;
  assign cpu_input_port  = s.in_data;
  assign cpu_status      = s.status;
  assign cpu_port2       = s.port2;
  // gate a20 straight from the port latch
  assign port2_bit1      = s.port2[P2_A20];
  assign test_input_zero = s.pin_fb[0];
  assign port1_bit0      = s.pin_fb[1];
  assign test_input_one  = s.pin_fb[2];
  assign port1_bit1      = s.pin_fb[3];
  // only the two cpu interrupt sources
  assign cpu_irq_ibf     = s.status[ST_IBF] & ibf_irq_en;
  assign cpu_irq_timer   = s.tmr_flag & tmr_irq_en;
  assign alu_clk_en      = (s.pwr == PWR_RUN) & (s.rst_cnt == '0);
  assign osc_en          = s.pwr != PWR_HARD;
  assign cpu_core_rst    = s.rst_cnt != '0;
  assign cpu_wake_call   = s.wake_call;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_kbd_clock_pin_rise;
    kbc_mode && !pin_open_drain && $fell(s.port2[P2_KBD_CLOCK_PIN]);
  endsequence
  // drive stays up through the last counted cycle, then drops exactly once
  sequence s_drive_window;
    kbm_pin_oe[0] [*8] ##41 kbm_pin_oe[0] ##1 !kbm_pin_oe[0];
  endsequence

  a_data_write_flags: assert property (
    host_data_wr |=> s.status[ST_IBF] && !s.status[ST_CD])
    else $error("data write flags wrong");
  a_cmd_write_flags: assert property (
    host_cmd_wr |=> s.status[ST_IBF] && s.status[ST_CD])
    else $error("command write flags wrong");
  a_read_clears_obf: assert property (
    host_data_rd && s.en_flags && !cpu_port2_wr && !fifo_pop
      |=> !s.status[ST_OBF] && !kbd_host_irq)
    else $error("flags-mode read did not clear");
  a_out_load_sets: assert property (
    fifo_pop |=> s.status[ST_OBF] && s.out_data == $past(fifo_data))
    else $error("output load lost");
  a_kbd_irq_masked: assert property (
    s.en_flags && !s.port2[P2_KBD_HOST_IRQ] |-> !kbd_host_irq)
    else $error("keyboard irq not masked");
  a_kbd_irq_direct: assert property (
    !s.en_flags && !cpu_en_flags && cpu_port2_wr
      |=> kbd_host_irq == $past(cpu_port2_wdata[P2_KBD_HOST_IRQ]))
    else $error("keyboard irq not following port");
  a_aux_irq_ibf: assert property (
    s.en_flags && s.status[ST_IBF] |-> !aux_host_irq)
    else $error("aux irq high while input full");
  a_drive_release: assert property (
    s_kbd_clock_pin_rise |-> ##1 s_drive_window)
    else $error("drive-high window wrong length");
  a_open_drain_z: assert property (
    kbc_mode && pin_open_drain && !s.port2[P2_MCLK] |-> !kbm_pin_oe[2] && kbm_pin_out[2])
    else $error("open drain pin driven");
  a_ibf_set_wins: assert property (
    host_data_wr && cpu_in_rd |=> s.status[ST_IBF])
    else $error("input full set lost");
  a_cpu_read_clear: assert property (
    cpu_in_rd && !host_data_wr && !host_cmd_wr |=> !s.status[ST_IBF] && !cpu_irq_ibf)
    else $error("cpu read did not clear");
  a_stop_wake_hold: assert property (
    s.pwr == PWR_HARD && host_data_wr |=> (osc_en && cpu_core_rst) [*8])
    else $error("wake from stop not held");

endmodule

// File: hw/kbcm_pkg.sv
// shared constants, carriers and state for the keyboard controller host mailbox
package kbcm_pkg;

  // -----------------------------------------------------------------
  // host i/o map and status layout
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA      = 8'h60;
  localparam logic [7:0] ADDR_CMD       = 8'h64;
  localparam logic [7:0] UNMAPPED_RDATA = 8'hFF;
  localparam int         ADDR_SEL_BIT   = 2;
  localparam int         ST_OBF         = 0;
  localparam int         ST_IBF         = 1;
  localparam int         ST_CD          = 3;
  localparam logic [7:0] ST_UD_MASK     = 8'hF4;
  localparam logic [7:0] STATUS_RST     = 8'h00;

  // -----------------------------------------------------------------
  // port 2 bit use; pin index 0 kbd_clock_pin, 1 kbd_data_pin, 2 mclk, 3 mouse_data_pin
  // -----------------------------------------------------------------
  localparam int         P2_A20    = 1;
  localparam int         P2_MOUSE_DATA_PIN   = 2;
  localparam int         P2_MCLK   = 3;
  localparam int         P2_KBD_HOST_IRQ   = 4;
  localparam int         P2_AIRQ   = 5;
  localparam int         P2_KBD_CLOCK_PIN   = 6;
  localparam int         P2_KBD_DATA_PIN   = 7;
  localparam logic [7:0] PORT2_RST = 8'hCC;
  localparam int         NUM_PINS  = 4;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_NS         = 10;
  localparam int DRIVE_HIGH_NS  = 500;
  localparam int DRIVE_HIGH_CYC = DRIVE_HIGH_NS / CLK_NS;
  localparam int RESET_HOLD_NS  = 1500;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRV_W          = 6;
  localparam int RST_W          = 8;
  localparam int FIFO_DEPTH     = 4;

  typedef enum logic [1:0] {PWR_RUN, PWR_SOFT, PWR_HARD} kbcm_pwr_t;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } kbcm_host_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } kbcm_host_rsp_t;

  typedef struct packed {
    logic [7:0]                      status;
    logic [7:0]                      in_data;
    logic [7:0]                      out_data;
    logic [7:0]                      port2;
    logic                            en_flags;
    logic                            kbd_irq;
    logic                            aux_irq;
    kbcm_host_rsp_t                  rsp;
    logic [NUM_PINS-1:0][DRV_W-1:0]  drv_cnt;
    logic [NUM_PINS-1:0]             pin_fb;
    kbcm_pwr_t                       pwr;
    logic [RST_W-1:0]                rst_cnt;
    logic                            tmr_flag;
    logic                            wake_call;
  } kbcm_state_t;

  localparam kbcm_state_t STATE_RST = '{
    status: STATUS_RST, in_data: 8'h00, out_data: 8'h00, port2: PORT2_RST,
    en_flags: 1'b0, kbd_irq: 1'b0, aux_irq: 1'b0, rsp: '0, drv_cnt: '0,
    pin_fb: '0, pwr: PWR_RUN, rst_cnt: RST_W'(RESET_HOLD_CYC),
    tmr_flag: 1'b0, wake_call: 1'b0};

endpackage

// File: test/kbcm_host_model.sv
// host processor model issuing byte i/o cycles to the mailbox
`timescale 1ns/1ps
module kbcm_host_model
  import kbcm_pkg::*;
(
  input  wire logic      core_clk,
  output kbcm_host_req_t host_req,
  input  kbcm_host_rsp_t host_rsp
);
  logic       last_ok;
  logic [7:0] last_rdata;

  initial host_req = '0;

  // host read or write cycle
  // one request, taken at the next edge, then released
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_req <= '{1'b1, rd, ~rd, a, d};
    @(posedge core_clk);
    // released lines flip, so a stale value never looks valid
    host_req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    #1;
    last_ok = host_rsp.valid;
    last_rdata = host_rsp.data;
  endtask
endmodule

// File: test/kbcm_host_mailbox_test.sv
// self-checking bench for the keyboard controller host mailbox
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
`define WAITF(c, n) begin int w_; w_ = 0; #1; comparisons++; \
  while (!(c) && w_ < (n)) begin @(posedge core_clk); #1; w_++; end \
  if (!(c)) begin bad_count++; $display("MISMATCH %0t wait ran out", $time); \
  test_done(); end end
`define PULSE(s) begin @(posedge core_clk); s <= 1'b1; @(posedge core_clk); s <= 1'b0; end
module kbcm_host_mailbox_test
  import kbcm_pkg::*;
;
  logic           core_clk, rst_n, kbd_host_irq, aux_host_irq, cpu_data_wr;
  logic           cpu_data_ready, cpu_obf_clr, cpu_in_rd, cpu_status_wr, cpu_en_flags;
  logic           cpu_port2_wr, port2_bit1, test_input_zero, test_input_one;
  logic           port1_bit0, port1_bit1, ibf_irq_en, tmr_irq_en, cpu_timer_ovf;
  logic           cpu_timer_ack, cpu_irq_ibf, cpu_irq_timer, cpu_halt, cpu_stop;
  logic           alu_clk_en, osc_en, cpu_core_rst, cpu_wake_call, kbc_mode;
  logic           pin_open_drain;
  logic [7:0]     cpu_data_port, cpu_input_port, cpu_status, cpu_status_wdata;
  logic [7:0]     cpu_port2_wdata, cpu_port2;
  logic [3:0]     gp_invert, gp_as_input, kbm_pin_in, kbm_pin_out, kbm_pin_oe;
  logic [3:0]     ext_low, rb;
  kbcm_host_req_t host_req;
  kbcm_host_rsp_t host_rsp;
  int             bad_count, comparisons;

  // pull-ups on every pin; ext_low is the far device holding a line low
  assign kbm_pin_in = ~((kbm_pin_oe & ~kbm_pin_out) | ext_low);
  assign rb = {port1_bit1, test_input_one, port1_bit0, test_input_zero};

  kbcm_host_model host (.core_clk, .host_req, .host_rsp);

  kbcm_host_mailbox dut (.core_clk, .rst_n, .host_req, .host_rsp, .kbd_host_irq,
    .aux_host_irq, .cpu_data_wr, .cpu_data_port, .cpu_data_ready, .cpu_obf_clr,
    .cpu_in_rd, .cpu_input_port, .cpu_status, .cpu_status_wr, .cpu_status_wdata,
    .cpu_en_flags, .cpu_port2_wr, .cpu_port2_wdata, .cpu_port2, .port2_bit1,
    .test_input_zero, .test_input_one, .port1_bit0, .port1_bit1, .ibf_irq_en,
    .tmr_irq_en, .cpu_timer_ovf, .cpu_timer_ack, .cpu_irq_ibf, .cpu_irq_timer,
    .cpu_halt, .cpu_stop, .alu_clk_en, .osc_en, .cpu_core_rst, .cpu_wake_call,
    .kbc_mode, .pin_open_drain, .gp_invert, .gp_as_input, .kbm_pin_in, .kbm_pin_out,
    .kbm_pin_oe);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic p2(input logic [7:0] v);
    @(posedge core_clk);
    cpu_port2_wr <= 1'b1;
    cpu_port2_wdata <= v;
    @(posedge core_clk);
    cpu_port2_wr <= 1'b0;
  endtask

  task automatic cw(input logic [7:0] v);
    @(posedge core_clk);
    cpu_data_wr <= 1'b1;
    cpu_data_port <= v;
    @(posedge core_clk);
    cpu_data_wr <= 1'b0;
  endtask

  task automatic rst_hold();
    int n;
    n = 0;
    while (cpu_core_rst === 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(n >= 145 && n <= 155, 1'b1)
    if (n == 300) test_done();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // state after reset
  task automatic t_reset();
    #1;
    `CHK({kbm_pin_out, kbm_pin_oe}, 8'h0F)
    `CHK({kbd_host_irq, aux_host_irq, cpu_data_ready}, 3'b001)
    rst_hold();
    `CHK(alu_clk_en, 1'b1)
    host.xfer(1'b1, ADDR_CMD, 8'h00);
    `CHK({host.last_ok, host.last_rdata}, 9'h100)
  endtask

  task automatic t_host();
    host.xfer(1'b0, ADDR_DATA, 8'hA5);
    `CHK({cpu_status[ST_CD], cpu_status[ST_IBF], cpu_input_port}, 10'h1A5)
    host.xfer(1'b1, ADDR_CMD, 8'h00);
    `CHK(host.last_rdata, 8'h02)
    `PULSE(cpu_in_rd)
    #1;
    `CHK(cpu_status[ST_IBF], 1'b0)
    host.xfer(1'b0, ADDR_CMD, 8'h3C);
    `CHK({cpu_status[ST_CD], cpu_status[ST_IBF], cpu_input_port}, 10'h33C)
    host.xfer(1'b1, ADDR_CMD, 8'h00);
    `CHK(host.last_rdata, 8'h0A)
    // host write and cpu read land on the same edge
    fork
      host.xfer(1'b0, ADDR_DATA, 8'h66);
      `PULSE(cpu_in_rd)
    join
    `CHK({cpu_status[ST_IBF], cpu_input_port}, 9'h166)
    `PULSE(cpu_in_rd)
    host.xfer(1'b0, 8'h61, 8'h99);
    `CHK({cpu_status[ST_IBF], cpu_input_port}, 9'h066)
    host.xfer(1'b1, 8'h61, 8'h00);
    `CHK(host.last_rdata, UNMAPPED_RDATA)
    @(posedge core_clk);
    cpu_status_wr <= 1'b1;
    cpu_status_wdata <= 8'hFF;
    @(posedge core_clk);
    cpu_status_wr <= 1'b0;
    host.xfer(1'b1, ADDR_CMD, 8'h00);
    `CHK(host.last_rdata, ST_UD_MASK)
  endtask

  task automatic t_irq();
    p2(8'hDE);
    `WAITF(kbd_host_irq === 1'b1 && aux_host_irq === 1'b0, 4)
    `CHK(port2_bit1, 1'b1)
    p2(8'hEC);
    `WAITF(kbd_host_irq === 1'b0 && aux_host_irq === 1'b1, 4)
    `CHK({port2_bit1, cpu_port2}, 9'h0EC)
    cw(8'h5A);
    `WAITF(cpu_status[ST_OBF] === 1'b1, 4)
    host.xfer(1'b1, ADDR_DATA, 8'h00);
    `CHK(host.last_rdata, 8'h5A)
    repeat (2) @(posedge core_clk);
    `CHK(cpu_status[ST_OBF], 1'b1)
    `PULSE(cpu_obf_clr)
    `WAITF(cpu_status[ST_OBF] === 1'b0, 3)
    `PULSE(cpu_en_flags)
    p2(8'hFC);
    `WAITF(aux_host_irq === 1'b1 && kbd_host_irq === 1'b0, 4)
    cw(8'h77);
    `WAITF(kbd_host_irq === 1'b1, 4)
    host.xfer(1'b1, ADDR_DATA, 8'h00);
    `CHK(host.last_rdata, 8'h77)
    `WAITF(kbd_host_irq === 1'b0 && cpu_status[ST_OBF] === 1'b0, 3)
    host.xfer(1'b0, ADDR_DATA, 8'h11);
    `WAITF(aux_host_irq === 1'b0, 4)
    `PULSE(cpu_in_rd)
    `WAITF(aux_host_irq === 1'b1, 4)
  endtask

  // queue fills, refuses, drains in order
  task automatic t_fifo();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      cpu_data_wr <= 1'b1;
      cpu_data_port <= 8'h30 + 8'(i);
    end
    @(posedge core_clk);
    cpu_data_wr <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK(cpu_data_ready, 1'b0)
    for (int i = 0; i < 5; i++) begin
      `WAITF(cpu_status[ST_OBF] === 1'b1, 4)
      host.xfer(1'b1, ADDR_DATA, 8'h00);
      `CHK(host.last_rdata, 8'h30 + 8'(i))
    end
    repeat (4) @(posedge core_clk);
    `CHK({cpu_data_ready, cpu_status[ST_OBF]}, 2'b10)
  endtask

  task automatic t_pins();
    int n;
    int pos [4] = '{6, 7, 3, 2};
    @(posedge core_clk);
    gp_invert <= 4'hF;
    gp_as_input <= 4'hF;
    // outside controller mode the same settings must take the pins
    @(posedge core_clk);
    kbc_mode <= 1'b0;
    `WAITF(kbm_pin_oe === 4'h0, 2)
    @(posedge core_clk);
    kbc_mode <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      pin_open_drain <= (p >= 2);
      p2(8'hFC & ~(8'h01 << pos[p]));
      `WAITF(kbm_pin_out[p] === 1'b1, 4)
      `CHK({kbm_pin_out & ~(4'h1 << p), kbm_pin_oe | (4'h1 << p)}, 8'h0F)
      n = 0;
      while (kbm_pin_oe[p] === 1'b1 && n < 100) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      `CHK(p >= 2 ? n <= 1 : (n >= 45 && n <= 52), 1'b1)
      if (n == 100) test_done();
      `WAITF(rb[p] === 1'b1, 4)
      @(posedge core_clk);
      ext_low[p] <= 1'b1;
      `WAITF(rb[p] === 1'b0, 4)
      @(posedge core_clk);
      ext_low[p] <= 1'b0;
      p2(8'hFC);
      `WAITF(kbm_pin_out[p] === 1'b0 && kbm_pin_oe[p] === 1'b1, 4)
    end
  endtask

  task automatic t_power();
    @(posedge core_clk);
    ibf_irq_en <= 1'b1;
    tmr_irq_en <= 1'b1;
    `PULSE(cpu_timer_ovf)
    `WAITF(cpu_irq_timer === 1'b1, 4)
    `PULSE(cpu_timer_ack)
    `WAITF(cpu_irq_timer === 1'b0, 4)
    `PULSE(cpu_halt)
    `WAITF(alu_clk_en === 1'b0 && osc_en === 1'b1, 4)
    host.xfer(1'b0, ADDR_DATA, 8'h42);
    `WAITF(cpu_wake_call === 1'b1, 4)
    `CHK({alu_clk_en, cpu_irq_ibf}, 2'b11)
    `PULSE(cpu_in_rd)
    `PULSE(cpu_stop)
    `WAITF(osc_en === 1'b0, 4)
    host.xfer(1'b0, ADDR_DATA, 8'h43);
    `WAITF(cpu_core_rst === 1'b1, 4)
    rst_hold();
    `CHK(osc_en, 1'b1)
    // halt wake with the input-full interrupt off goes straight on
    @(posedge core_clk);
    ibf_irq_en <= 1'b0;
    `PULSE(cpu_halt)
    host.xfer(1'b0, ADDR_DATA, 8'h44);
    `CHK({cpu_wake_call, alu_clk_en}, 2'b01)
    `PULSE(cpu_halt)
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (24) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
  endtask

  initial begin
    rst_n = 1'b0;
    {cpu_data_wr, cpu_obf_clr, cpu_in_rd, cpu_status_wr, cpu_en_flags, cpu_port2_wr,
     ibf_irq_en, tmr_irq_en, cpu_timer_ovf, cpu_timer_ack, cpu_halt, cpu_stop,
     pin_open_drain} = '0;
    {cpu_data_port, cpu_status_wdata, cpu_port2_wdata} = '0;
    {gp_invert, gp_as_input, ext_low} = '0;
    kbc_mode = 1'b1;
    bad_count = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_host();
    t_irq();
    t_fifo();
    t_pins();
    t_power();
    test_done();
  end
endmodule
